// ---- mtr_panel_model.sv ----
// Purpose: Behavioural touch-panel controller on the open-drain serial bus.
// Assumes: The reader sets data while the serial clock is low.
// Notes: Pulls the data line low only; the bench supplies the pull-up.
`timescale 1ns/1ps
`default_nettype none
module mtr_panel_model #(
    parameter logic [6:0] ADDR = 7'h38
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic refuse,
    input wire logic [79:0] burst,
    output logic sda_pull
);
    logic [7:0] rx;
    logic acked;
    // Shifts a byte in, then acknowledges it unless the address is refused or does not match ADDR.
    task automatic take(input logic is_addr);
        rx = 8'h00;
        repeat (8) begin
            @(posedge scl);
            rx = {rx[6:0], sda};
        end
        acked = !is_addr || (!refuse && rx[7:1] == ADDR);
        @(negedge scl);
        sda_pull = acked;
        @(negedge scl);
        sda_pull = 1'b0;
    endtask
    // Waits for a start, then serves a pointer write or a ten-byte read.
    initial begin
        sda_pull = 1'b0;
        forever begin
            @(negedge sda iff scl === 1'b1);
            take(1'b1);
            if (acked && !rx[0]) begin
                take(1'b0);
            end else if (acked) begin
                for (int k = 0; k < 80; k++) begin
                    sda_pull = !burst[79 - k];
                    @(negedge scl);
                    if (k % 8 == 7) begin
                        sda_pull = 1'b0;
                        @(negedge scl);
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- mtr_pkg.sv ----
// Purpose: Shared constants, types and report layout for the touch-panel gesture reader.
// Assumes: The core clock runs at 250 MHz and the serial link runs near 100 kHz.
// Notes: Report bytes are read in one burst starting at a fixed register pointer.
package mtr_pkg;

    // Core clock rate and the serial clock period that the master generates.
    localparam int CLK_MHZ = 250;
    localparam int SCL_PERIOD_NS = 10000;
    // A least period, so the quarter count rounds up.
    localparam int QTR_CYC = (SCL_PERIOD_NS * CLK_MHZ + 3999) / 4000;
    localparam int QTR_W = 10;
    localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

    // Report field widths.
    localparam int X_W = 10;
    localparam int Y_W = 9;
    localparam int CNT_W = 2;
    localparam int GEST_W = 8;

    // Burst layout: byte index of each field within the read burst.
    localparam int BYTES = 10;
    localparam logic [3:0] LAST_BYTE = 4'(BYTES - 1);
    localparam int B_GEST = 0;
    localparam int B_CNT = 1;
    localparam int B_AXH = 2;
    localparam int B_AXL = 3;
    localparam int B_AYH = 4;
    localparam int B_AYL = 5;
    localparam int B_BXH = 6;
    localparam int B_BXL = 7;
    localparam int B_BYH = 8;
    localparam int B_BYL = 9;

    // Bit counter value of the acknowledge slot, and the last quarter phase.
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] PH_LAST = 2'h3;

    // Finger count ceiling and gesture codes.
    localparam logic [CNT_W-1:0] MAX_FINGERS = 2'h2;
    localparam logic [GEST_W-1:0] GEST_NONE = 8'h00;
    localparam logic [GEST_W-1:0] G1_NORTH = 8'h10;
    localparam logic [GEST_W-1:0] G1_NWEST = 8'h1E;
    localparam logic [GEST_W-1:0] G1_CLICK = 8'h20;
    localparam logic [GEST_W-1:0] G1_DCLICK = 8'h22;
    localparam logic [GEST_W-1:0] G1_ROT_CW = 8'h28;
    localparam logic [GEST_W-1:0] G1_ROT_ACW = 8'h29;
    localparam logic [GEST_W-1:0] G2_NORTH = 8'h30;
    localparam logic [GEST_W-1:0] G2_NWEST = 8'h3E;
    localparam logic [GEST_W-1:0] G2_CLICK = 8'h40;
    localparam logic [GEST_W-1:0] G2_ZOOM_IN = 8'h48;
    localparam logic [GEST_W-1:0] G2_ZOOM_OUT = 8'h49;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_TX = 3'b010,
        ST_RX = 3'b011,
        ST_STOP = 3'b100,
        ST_DONE = 3'b101,
        ST_FLAG = 3'b110
    } mtr_state_e;

    // One complete touch report as presented to the host logic.
    typedef struct packed {
        logic [X_W-1:0] a_x;
        logic [Y_W-1:0] a_y;
        logic [X_W-1:0] b_x;
        logic [Y_W-1:0] b_y;
        logic [CNT_W-1:0] count;
        logic [GEST_W-1:0] gesture;
    } mtr_report_s;

endpackage

// ---- mtr_reader.sv ----
// Purpose: Serial-bus master that reads touch reports from a panel controller.
// Assumes: The controller pulls its interrupt low while a report waits.
// Notes: Data line is open drain; the serial clock is driven push-pull.
//
// What this block does
// - All logic and all host outputs run from the single core clock.
// - The valid strobe rises only after all six report outputs hold the new report.
// - The first point is a 10-bit horizontal and a 9-bit vertical coordinate.
// - The second point uses the same 10-bit and 9-bit format as the first.
// - The finger count is 2 bits and only ever carries 0, 1 or 2.
// - The gesture output is an 8-bit code naming the detected gesture.
// - One-finger codes are even 0x10 to 0x1E, click 0x20, double 0x22, rotate 0x28 and 0x29.
// - Two-finger codes are even 0x30 to 0x3E, click 0x40, zoom 0x48 and 0x49.
// - The reader is master, drives the serial clock and drives and samples the data line.
`timescale 1ns/1ps
`default_nettype none
module mtr_reader #(
    parameter logic [6:0] DEV_ADDR = 7'h38,
    parameter logic [7:0] REG_START = 8'h00,
    parameter int QTR_COUNT = mtr_pkg::QTR_CYC // Clocks per quarter bit; sets the serial rate.
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic touch_irq_n_in,
    output logic report_valid_out,
    output logic [mtr_pkg::X_W-1:0] point_a_x,
    output logic [mtr_pkg::Y_W-1:0] point_a_y,
    output logic [mtr_pkg::X_W-1:0] point_b_x,
    output logic [mtr_pkg::Y_W-1:0] point_b_y,
    output logic [mtr_pkg::CNT_W-1:0] finger_count,
    output logic [mtr_pkg::GEST_W-1:0] gesture_code,
    output logic serial_clk_out,
    input wire logic serial_data_io_in,
    output logic serial_data_io_out,
    output logic serial_data_io_oe
);
    import mtr_pkg::*;

    // True for every code in the one-finger and two-finger gesture tables.
    function automatic logic gesture_known(input logic [GEST_W-1:0] code);
        logic one_dir;
        logic two_dir;
        one_dir = (code >= G1_NORTH) && (code <= G1_NWEST) && !code[0];
        two_dir = (code >= G2_NORTH) && (code <= G2_NWEST) && !code[0];
        gesture_known = one_dir || two_dir
            || (code == G1_CLICK) || (code == G1_DCLICK)
            || (code == G1_ROT_CW) || (code == G1_ROT_ACW)
            || (code == G2_CLICK) || (code == G2_ZOOM_IN)
            || (code == G2_ZOOM_OUT);
    endfunction

    mtr_state_e state_q;
    logic [1:0] sync0_q;
    logic [1:0] sync1_q;
    logic [QTR_W-1:0] qtr_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [3:0] byte_q;
    logic [1:0] seq_q;
    logic [7:0] shift_q;
    logic nack_q;
    logic fail_q;
    logic valid_q;
    logic scl_q;
    logic oe_q;
    logic [7:0] buf_q [0:BYTES-1];
    mtr_report_s report_q;

    // Both pins come from outside the clock domain; each passes two flops before use.
    // The first stage is read only by the second stage.
    logic [1:0] pin_raw;
    assign pin_raw = {serial_data_io_in, touch_irq_n_in};
    generate
        for (genvar i = 0; i < 2; i++) begin : g_sync
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    sync0_q[i] <= 1'b1;
                    sync1_q[i] <= 1'b1;
                end else begin
                    sync0_q[i] <= pin_raw[i];
                    sync1_q[i] <= sync0_q[i];
                end
            end
        end
    endgenerate

    // Quarter length is a parameter so another serial rate needs no package change.
    localparam logic [QTR_W-1:0] QTR_END = QTR_W'(QTR_COUNT - 1);

    wire irq_pend = !sync1_q[0];
    wire sda_s = sync1_q[1];
    wire busy = (state_q == ST_START) || (state_q == ST_TX)
        || (state_q == ST_RX) || (state_q == ST_STOP);
    wire tick = busy && (qtr_q == QTR_END);
    wire ph_end = tick && (ph_q == PH_LAST);
    wire ph_sample = tick && (ph_q == 2'h2);
    wire in_ack = (bit_q == ACK_BIT);
    wire last_byte = (byte_q == LAST_BYTE);

    // Line levels per state and quarter: clock high in the middle two quarters of a bit, and in the last three quarters of the stop.
    // Data only changes in quarters where the clock is low, except start and stop edges.
    wire ph_mid = (ph_q == 2'h1) || (ph_q == 2'h2);
    wire scl_d = (state_q == ST_START || state_q == ST_TX || state_q == ST_RX) ? ph_mid
        : (state_q == ST_STOP) ? (ph_q != 2'h0) : 1'b1;
    wire oe_d = (state_q == ST_START) ? ph_q[1]
        : (state_q == ST_TX) ? (!in_ack && !shift_q[7])
        : (state_q == ST_RX) ? (in_ack && !last_byte)
        : (state_q == ST_STOP) ? !ph_q[1] : 1'b0;

    // Report decode from the burst; the count is clamped and unknown gestures read as none.
    wire [7:0] cnt_raw = buf_q[B_CNT];
    wire [CNT_W-1:0] cnt_dec = (cnt_raw > 8'(MAX_FINGERS)) ? MAX_FINGERS
        : cnt_raw[CNT_W-1:0];
    wire [GEST_W-1:0] gest_dec = gesture_known(buf_q[B_GEST]) ? buf_q[B_GEST]
        : GEST_NONE;
    mtr_report_s report_d;
    assign report_d.a_x = {buf_q[B_AXH][1:0], buf_q[B_AXL]};
    assign report_d.a_y = {buf_q[B_AYH][0], buf_q[B_AYL]};
    assign report_d.b_x = {buf_q[B_BXH][1:0], buf_q[B_BXL]};
    assign report_d.b_y = {buf_q[B_BYH][0], buf_q[B_BYL]};
    assign report_d.count = cnt_dec;
    assign report_d.gesture = gest_dec;

    // Quarter-bit timer; it only runs while a transfer is on the wire.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            qtr_q <= '0;
        end else begin
            qtr_q <= (!busy || tick) ? '0 : qtr_q + 1'b1;
        end
    end

    // Pin drivers are registered so the pins never glitch on decode changes.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q <= 1'b1;
            oe_q <= 1'b0;
        end else begin
            scl_q <= scl_d;
            oe_q <= oe_d;
        end
    end

    // Transfer sequencer: write pointer, repeated start, read burst, stop, publish.
    // A missing acknowledge aborts with a stop; the still-low interrupt then retries.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            byte_q <= 4'h0;
            seq_q <= 2'h0;
            shift_q <= 8'h00;
            nack_q <= 1'b0;
            fail_q <= 1'b0;
            valid_q <= 1'b0;
            report_q <= '0;
            for (int k = 0; k < BYTES; k++) begin
                buf_q[k] <= 8'h00;
            end
        end else begin
            valid_q <= 1'b0;
            if (tick) begin
                ph_q <= ph_q + 2'h1;
            end
            case (state_q)
                ST_IDLE: begin
                    ph_q <= 2'h0;
                    if (irq_pend) begin
                        state_q <= ST_START;
                        seq_q <= 2'h0;
                        fail_q <= 1'b0;
                    end
                end
                ST_START: begin
                    if (ph_end) begin
                        state_q <= ST_TX;
                        bit_q <= 4'h0;
                        shift_q <= {DEV_ADDR, seq_q[1]};
                    end
                end
                ST_TX: begin
                    if (ph_sample && in_ack) begin
                        nack_q <= sda_s;
                    end
                    if (ph_end) begin
                        if (!in_ack) begin
                            bit_q <= bit_q + 4'h1;
                            shift_q <= {shift_q[6:0], 1'b0};
                        end else if (nack_q) begin
                            fail_q <= 1'b1;
                            state_q <= ST_STOP;
                        end else if (seq_q == 2'h0) begin
                            shift_q <= REG_START;
                            bit_q <= 4'h0;
                            seq_q <= 2'h1;
                        end else if (seq_q == 2'h1) begin
                            state_q <= ST_START;
                            seq_q <= 2'h2;
                        end else begin
                            state_q <= ST_RX;
                            bit_q <= 4'h0;
                            byte_q <= 4'h0;
                        end
                    end
                end
                ST_RX: begin
                    if (ph_sample && !in_ack) begin
                        shift_q <= {shift_q[6:0], sda_s};
                    end
                    if (ph_end) begin
                        if (!in_ack) begin
                            bit_q <= bit_q + 4'h1;
                        end else begin
                            buf_q[byte_q] <= shift_q;
                            bit_q <= 4'h0;
                            if (last_byte) begin
                                state_q <= ST_STOP;
                            end else begin
                                byte_q <= byte_q + 4'h1;
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (ph_end) begin
                        state_q <= fail_q ? ST_IDLE : ST_DONE;
                    end
                end
                ST_DONE: begin
                    report_q <= report_d;
                    state_q <= ST_FLAG;
                end
                ST_FLAG: begin
                    valid_q <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Every output except the tied-low serial_data_io_out is a flop or a field of one.
    assign report_valid_out = valid_q;
    assign point_a_x = report_q.a_x;
    assign point_a_y = report_q.a_y;
    assign point_b_x = report_q.b_x;
    assign point_b_y = report_q.b_y;
    assign finger_count = report_q.count;
    assign gesture_code = report_q.gesture;
    assign serial_clk_out = scl_q;
    assign serial_data_io_oe = oe_q;
    assign serial_data_io_out = 1'b0; // Open drain: only ever pulls low.

endmodule
`default_nettype wire

// ---- mtr_reader_monitor.sv ----
// Purpose: Property checks on the reader's host strobe and serial pins.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Attached to every reader instance by the bind below.
`timescale 1ns/1ps
`default_nettype none
module mtr_reader_mon #(
    parameter int QTR_COUNT = mtr_pkg::QTR_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic report_valid_out,
    input wire logic [mtr_pkg::X_W-1:0] point_a_x,
    input wire logic [mtr_pkg::Y_W-1:0] point_a_y,
    input wire logic [mtr_pkg::X_W-1:0] point_b_x,
    input wire logic [mtr_pkg::Y_W-1:0] point_b_y,
    input wire logic [mtr_pkg::CNT_W-1:0] finger_count,
    input wire logic [mtr_pkg::GEST_W-1:0] gesture_code,
    input wire logic serial_clk_out,
    input wire logic serial_data_io_oe
);
    import mtr_pkg::*;
    localparam int HI_MIN = 2 * QTR_COUNT - 2;
    logic [15:0] hi_q;
    logic [15:0] hi_d;
    logic gest_ok;
    logic [$bits(mtr_report_s)-1:0] fields;
    // The high-time count saturates, so a long idle never wraps to a small value.
    assign hi_d = serial_clk_out ? ((hi_q == 16'hFFFF) ? hi_q : hi_q + 16'h1) : 16'h0;
    assign fields = {point_a_x, point_a_y, point_b_x, point_b_y, finger_count, gesture_code};
    assign gest_ok = (gesture_code[7:4] inside {4'h1, 4'h3} && !gesture_code[0])
        || (gesture_code inside {G1_CLICK, G1_DCLICK, G1_ROT_CW, G1_ROT_ACW, G2_CLICK,
        G2_ZOOM_IN, G2_ZOOM_OUT, GEST_NONE});
    // Counts how long the serial clock has stood high.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_q <= 16'h0;
        end else begin
            hi_q <= hi_d;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_start;
        serial_clk_out && $rose(serial_data_io_oe);
    endsequence
    sequence s_bus_free;
        serial_clk_out && !serial_data_io_oe && $past(serial_clk_out, 8);
    endsequence
    chk_valid_pulse: assert property (report_valid_out |=> !report_valid_out)
        else $error("valid strobe stood longer than one cycle");
    chk_fields_settled: assert property (report_valid_out |-> $stable(fields))
        else $error("report fields moved in the valid cycle");
    chk_fields_lead: assert property ($changed(fields) |=> report_valid_out)
        else $error("report fields moved without a following strobe");
    chk_count_range: assert property (finger_count != 2'h3)
        else $error("finger count out of range");
    chk_gesture_known: assert property (report_valid_out |-> gest_ok)
        else $error("undefined gesture code reported");
    chk_start_hold: assert property (s_start |-> serial_clk_out [*8])
        else $error("serial clock fell right after a start");
    chk_scl_high: assert property ($fell(serial_clk_out) && serial_data_io_oe |->
        hi_q >= HI_MIN) else $error("serial clock high phase too short");
    chk_valid_idle: assert property (report_valid_out |-> s_bus_free)
        else $error("valid strobe before the bus was released");
endmodule
bind mtr_reader mtr_reader_mon #(.QTR_COUNT(QTR_COUNT)) u_mtr_reader_mon (.sys_clk(sys_clk),
    .arst_n(arst_n),
    .report_valid_out(report_valid_out), .point_a_x(point_a_x), .point_a_y(point_a_y),
    .point_b_x(point_b_x), .point_b_y(point_b_y), .finger_count(finger_count),
    .gesture_code(gesture_code), .serial_clk_out(serial_clk_out),
    .serial_data_io_oe(serial_data_io_oe));
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the touch report reader.
// Assumes: A ten-clock quarter makes a full report read take about five thousand clocks.
// Notes: The panel model serves random report bursts.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mtr_pkg::*;
    // A short quarter keeps the run brief; it stays above the sync delay and the start-hold check.
    localparam int QTR_TB = 10;
    logic sys_clk;
    logic arst_n;
    logic irq_n;
    logic refuse;
    logic [79:0] burst;
    logic [79:0] r;
    logic [7:0] g;
    wire logic sda;
    wire logic scl;
    wire logic oe;
    wire logic od;
    wire logic pull;
    wire logic valid;
    wire mtr_report_s got;
    int fails;
    int check_count;
    int vcount;
    mtr_reader #(.QTR_COUNT(QTR_TB)) u_mtr_reader (.sys_clk(sys_clk), .arst_n(arst_n),
        .touch_irq_n_in(irq_n), .report_valid_out(valid), .point_a_x(got.a_x),
        .point_a_y(got.a_y),
        .point_b_x(got.b_x), .point_b_y(got.b_y), .finger_count(got.count),
        .gesture_code(got.gesture), .serial_clk_out(scl), .serial_data_io_in(sda),
        .serial_data_io_out(od), .serial_data_io_oe(oe));
    mtr_panel_model u_mtr_panel_model (.scl(scl), .sda(sda), .refuse(refuse),
        .burst(burst), .sda_pull(pull));
    // Open-drain data line with a pull-up.
    assign sda = oe ? od : (pull ? 1'b0 : 1'b1);
    function automatic logic known(input logic [7:0] c);
        return (c[7:4] inside {4'h1, 4'h3} && !c[0])
            || (c inside {8'h20, 8'h22, 8'h28, 8'h29, 8'h40, 8'h48, 8'h49});
    endfunction
    function automatic mtr_report_s expect_of(input logic [79:0] b);
        mtr_report_s e;
        e.gesture = known(b[79:72]) ? b[79:72] : 8'h00;
        e.count = (b[71:64] > 8'h02) ? 2'h2 : b[65:64];
        e.a_x = b[57:48];
        e.a_y = b[40:32];
        e.b_x = b[25:16];
        e.b_y = b[8:0];
        return e;
    endfunction
    task automatic check(input logic [47:0] got_v, input logic [47:0] exp_v);
        check_count++;
        if (got_v !== exp_v) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Sampled on the falling edge so the strobe has settled.
    task automatic wait_valid();
        int n;
        n = 0;
        while (valid !== 1'b1 && n < 20000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 20000) fails++;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Counts strobes, so a double or missing one shows up.
    always @(posedge sys_clk) begin
        if (valid === 1'b1) vcount++;
    end
    initial begin
        #200000;
        fails++;
        conclude();
    end
    initial begin
        arst_n = 1'b0;
        irq_n = 1'b1;
        refuse = 1'b0;
        burst = '0;
        fails = 0;
        check_count = 0;
        vcount = 0;
        g = 8'($urandom(32'hC7D6));
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        // A refused address ends the transfer with no report.
        refuse <= 1'b1;
        irq_n <= 1'b0;
        repeat (200) @(posedge sys_clk);
        irq_n <= 1'b1;
        repeat (2000) @(posedge sys_clk);
        check(got, '0);
        check(48'(vcount), 48'h0);
        // An odd code and a count of 255 first, then a random known gesture back to back.
        for (int i = 0; i < 2; i++) begin
            do g = 8'($urandom); while (i == 1 && !known(g));
            r = {(i == 0) ? 8'h11 : g, (i == 0) ? 8'hFF : 8'($urandom % 3), $urandom, $urandom};
            @(posedge sys_clk);
            burst <= r;
            refuse <= 1'b0;
            irq_n <= 1'b0;
            // The hold is shorter than one read, so the final release lands inside a read.
            repeat (200) @(posedge sys_clk);
            irq_n <= (i == 1) ? 1'b1 : 1'b0;
            wait_valid();
            check(got, expect_of(r));
        end
        repeat (2000) @(posedge sys_clk);
        check(48'(vcount), 48'h2);
        conclude();
    end
endmodule
`default_nettype wire
